/* File: include/esc_write_defines.vh */
`ifndef ESC_WRITE_DEFINES_VH
`define ESC_WRITE_DEFINES_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL      8'h00
`define OFS_ADP       8'h04
`define OFS_ADO       8'h08
`define OFS_LEN       8'h0c
`define OFS_CMD       8'h10
`define OFS_VALUE     8'h14
`define OFS_STATUS    8'h18
`define OFS_FAULT     8'h1c
`define OFS_WKC       8'h20
`define OFS_INT_STAT  8'h24
`define OFS_INT_MASK  8'h28
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_TRIG      0
`define BIT_DONE      0
`define BIT_BUSY      1
`define BIT_ERROR     2
// ----------------------------------------------------------------
// Command codes and limits
// ----------------------------------------------------------------
`define CMD_APWR      16'h0002
`define CMD_FPWR      16'h0005
`define CMD_BWR       16'h0008
`define LEN_MIN       16'h0001
`define LEN_MAX       16'h0004
`define AP_LAST       16'hffc1
`define FP_MIN        16'h0001
`define FP_MAX        16'h0040
// ----------------------------------------------------------------
// Fault codes
// ----------------------------------------------------------------
`define FAULT_NONE    16'h0000
`define FAULT_ADP     16'h0f70
`define FAULT_LEN     16'h0f71
`define FAULT_CMD     16'h0f72
`define FAULT_NO_WKC  16'h0f73
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_WORD      32'h0000_0000
`define RST_HALF      16'h0000
`endif

/* File: rtl/slave_register_write_block.v */
// How it works
// RULE1 - Start only on trigger rising edge
// RULE2 - Byte count 1..4 else fault 0x0F71
// RULE3 - Codes 2,5,8 pick APWR, FPWR, BWR
// RULE4 - Other command codes give fault 0x0F72
// RULE5 - Address out of range gives fault 0x0F70
// RULE6 - Broadcast ignores position address entirely
// RULE7 - Auto-increment accepts 0x0000 down to 0xFFC1
// RULE8 - Configured address accepts 1 through 64
// RULE9 - Slave seeing address zero performs write
// RULE10 - Matching station address slave writes bytes
// RULE11 - Broadcast: every slave writes, counts one
// RULE12 - Working count zero at start, shown at done
// RULE13 - Each writing slave adds one to count
// RULE14 - Done only after slave wrote normally
// RULE15 - Write only low bytes of value
// RULE16 - Register offset becomes target address
// RULE17 - Busy during transaction; error with fault code
// RULE18 - No done with error; ignore triggers while busy
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "esc_write_defines.vh"
module slave_register_write_block (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         req_valid,
  input  wire        req_ready,
  output reg  [15:0] req_cmd,
  output reg  [15:0] req_adp,
  output reg  [15:0] req_ado,
  output reg  [2:0]  req_len,
  output reg  [31:0] req_data,
  input  wire        resp_valid,
  input  wire [15:0] resp_wkc,
  output reg         done,
  output reg         busy,
  output reg         error,
  output reg         irq
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  // Idle, request offered, result awaited
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_SEND = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Sequencer state and trigger history
  reg [1:0]  state_q;
  reg        trig_q;
  reg        trig_prev_q;

  // Request fields as software last wrote them
  reg [15:0] adp_q;
  reg [15:0] ado_q;
  reg [15:0] len_q;
  reg [15:0] cmd_q;
  reg [31:0] value_q;

  // Outcome of the last transaction
  reg [15:0] fault_q;
  reg [15:0] wkc_q;

  // Sticky event bits and their enables
  reg [1:0]  int_stat_q;
  reg [1:0]  int_mask_q;

  // Combinational helpers
  reg [31:0] rd_d;
  reg        hit_d;
  reg        bad_len;
  reg        bad_cmd;
  reg        bad_adp;
  reg [31:0] mask_d;
  reg [1:0]  int_stat_d;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Setup cycle and completing write access
  wire setup  = psel & ~penable;
  wire wr_acc = psel & penable & pready & pwrite;
  // Only the 0 to 1 step of the trigger counts, and only while idle, so
  // edges during a transfer are dropped rather than queued
  wire start  = trig_q & ~trig_prev_q & (state_q == ST_IDLE); // RULE1 RULE18
  wire ev_done;
  wire ev_err;

  // Read mux and address hit for the setup cycle
  // Unmapped offsets read zero and raise pslverr
  always @* begin
    rd_d  = `RST_WORD;
    hit_d = 1'b1;
    case (paddr)
      `OFS_CTRL:     rd_d = {31'h0000_0000, trig_q};
      `OFS_ADP:      rd_d = {16'h0000, adp_q};
      `OFS_ADO:      rd_d = {16'h0000, ado_q};
      `OFS_LEN:      rd_d = {16'h0000, len_q};
      `OFS_CMD:      rd_d = {16'h0000, cmd_q};
      `OFS_VALUE:    rd_d = value_q;
      `OFS_STATUS:   rd_d = {29'h0000_0000, error, busy, done};
      `OFS_FAULT:    rd_d = {16'h0000, fault_q};
      `OFS_WKC:      rd_d = {16'h0000, wkc_q};
      `OFS_INT_STAT: rd_d = {30'h0000_0000, int_stat_q};
      `OFS_INT_MASK: rd_d = {30'h0000_0000, int_mask_q};
      default:       hit_d = 1'b0;
    endcase
  end

  // No wait states: ready rises in the first access cycle
  // Read data is frozen at setup so the access returns one snapshot
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RST_WORD;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_d;
      if (setup) begin
        prdata <= rd_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Writes land at the completing access edge; a trigger write is
  // seen as an edge one cycle later
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_q      <= 1'b0;
      trig_prev_q <= 1'b0;
      adp_q       <= `RST_HALF;
      ado_q       <= `RST_HALF;
      len_q       <= `RST_HALF;
      cmd_q       <= `RST_HALF;
      value_q     <= `RST_WORD;
      int_mask_q  <= 2'b00;
    end else begin
      trig_prev_q <= trig_q;
      if (wr_acc) begin
        case (paddr)
          `OFS_CTRL:     trig_q     <= pwdata[`BIT_TRIG];
          `OFS_ADP:      adp_q      <= pwdata[15:0];
          `OFS_ADO:      ado_q      <= pwdata[15:0];
          `OFS_LEN:      len_q      <= pwdata[15:0];
          `OFS_CMD:      cmd_q      <= pwdata[15:0];
          `OFS_VALUE:    value_q    <= pwdata;
          `OFS_INT_MASK: int_mask_q <= pwdata[1:0];
          default:       trig_q     <= trig_q;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Request checks
  // ----------------------------------------------------------------
  // Fault priority is count, then command, then address
  // Auto-increment wraps: 0 is the first slave, 0xffff the second
  always @* begin
    bad_len = (len_q < `LEN_MIN) || (len_q > `LEN_MAX); // RULE2
    bad_cmd = 1'b0;
    bad_adp = 1'b0;
    case (cmd_q) // RULE3
      `CMD_APWR: bad_adp = (adp_q != `RST_HALF) && (adp_q < `AP_LAST); // RULE5 RULE7
      `CMD_FPWR: bad_adp = (adp_q < `FP_MIN) || (adp_q > `FP_MAX);    // RULE5 RULE8
      `CMD_BWR:  bad_adp = 1'b0;                                       // RULE6
      default:   bad_cmd = 1'b1;                                       // RULE4
    endcase
  end

  // Byte mask from count
  // Bytes above the count are forced to zero so no stale data leaves
  always @* begin
    case (len_q[2:0])
      3'd1:    mask_d = 32'h0000_00ff;
      3'd2:    mask_d = 32'h0000_ffff;
      3'd3:    mask_d = 32'h00ff_ffff;
      default: mask_d = 32'hffff_ffff;
    endcase
  end

  // ----------------------------------------------------------------
  // Transaction sequencer
  // ----------------------------------------------------------------
  // Idle checks the request on a trigger edge; send holds the request
  // until the network takes it; wait keeps busy high until the result
  // returns, then done or error stands until the next start
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      req_valid <= 1'b0;
      req_cmd   <= `RST_HALF;
      req_adp   <= `RST_HALF;
      req_ado   <= `RST_HALF;
      req_len   <= 3'd0;
      req_data  <= `RST_WORD;
      done      <= 1'b0;
      busy      <= 1'b0;
      error     <= 1'b0;
      fault_q   <= `FAULT_NONE;
      wkc_q     <= `RST_HALF;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            done    <= 1'b0;
            error   <= 1'b0;
            wkc_q   <= `RST_HALF; // RULE12
            fault_q <= `FAULT_NONE;
            if (bad_len) begin
              error   <= 1'b1; // RULE2 RULE17
              fault_q <= `FAULT_LEN;
            end else if (bad_cmd) begin
              error   <= 1'b1; // RULE4 RULE17
              fault_q <= `FAULT_CMD;
            end else if (bad_adp) begin
              error   <= 1'b1; // RULE5 RULE17
              fault_q <= `FAULT_ADP;
            end else begin
              busy      <= 1'b1; // RULE17
              req_valid <= 1'b1;
              req_cmd   <= cmd_q;
              req_adp   <= (cmd_q == `CMD_BWR) ? `RST_HALF : adp_q; // RULE6
              req_ado   <= ado_q;            // RULE16
              req_len   <= len_q[2:0];
              req_data  <= value_q & mask_d; // RULE15
              state_q   <= ST_SEND;
            end
          end
        end
        ST_SEND: begin
          // The network may stall; the request stands until it is taken
          if (req_ready) begin
            req_valid <= 1'b0;
            state_q   <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (resp_valid) begin
            busy    <= 1'b0; // RULE18
            wkc_q   <= resp_wkc; // RULE12 RULE13
            state_q <= ST_IDLE;
            // A zero count means no slave wrote: reported as a fault
            if (resp_wkc != `RST_HALF) begin
              done <= 1'b1; // RULE14 RULE11
            end else begin
              error   <= 1'b1; // RULE17 RULE18
              fault_q <= `FAULT_NO_WKC;
            end
          end
        end
        default: begin
          // Unused code falls back to idle with the request withdrawn
          state_q   <= ST_IDLE;
          req_valid <= 1'b0;
          busy      <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // One-cycle event strobes at the edge that sets done or error
  assign ev_done = (state_q == ST_WAIT) & resp_valid & (resp_wkc != `RST_HALF);
  assign ev_err  = (start & (bad_len | bad_cmd | bad_adp)) |
                   ((state_q == ST_WAIT) & resp_valid & (resp_wkc == `RST_HALF));

  // Write one clears; a new event wins over the clear
  // so an event in the clearing cycle is never lost
  always @* begin
    int_stat_d = int_stat_q;
    if (wr_acc && (paddr == `OFS_INT_STAT)) begin
      int_stat_d = int_stat_q & ~pwdata[1:0];
    end
    int_stat_d = int_stat_d | {ev_err, ev_done};
  end

  // irq follows the next status value so it rises with the bit
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_q <= 2'b00;
      irq        <= 1'b0;
    end else begin
      int_stat_q <= int_stat_d;
      irq        <= |(int_stat_d & int_mask_q);
    end
  end
endmodule
`default_nettype wire

/* File: tb/esc_net_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ------
// Slave chain seen from the master
// ------
module esc_net_model #(parameter int NSLV = 3) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic        req_valid,
  input  wire logic [15:0] req_cmd,
  input  wire logic [15:0] req_adp,
  output logic             req_ready,
  output logic             resp_valid,
  output logic [15:0]      resp_wkc,
  output int               n_req
);
  int          w;
  logic [15:0] wkc;
  // Count the slaves that take the write
  always_comb begin
    case (req_cmd)
      16'h0002: wkc = 16'(16'(-req_adp) < NSLV);
      16'h0005: wkc = 16'(req_adp >= 1 && req_adp <= NSLV);
      default:  wkc = 16'(NSLV);
    endcase
  end
  // Take one request, then answer; count lines toggle in every cycle but the answer cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w <= 0;
      n_req <= 0;
      req_ready <= 0;
      resp_valid <= 0;
      resp_wkc <= 0;
    end else begin
      if (req_valid && w == 0) begin
        w <= slow ? 20 : 4;
        n_req <= n_req + 1;
      end
      if (w > 0)
        w <= w - 1;
      req_ready <= w == 3;
      resp_valid <= w == 1;
      resp_wkc <= w == 1 ? wkc : ~resp_wkc;
    end
  end
endmodule
`default_nettype wire

/* File: tb/slave_register_write_block_chk.sv */
`timescale 1ns/1ns
`default_nettype none
// ------
// Port checks
// ------
module slave_register_write_block_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [15:0] req_cmd,
  input wire logic [15:0] req_adp,
  input wire logic [2:0]  req_len,
  input wire logic [31:0] req_data,
  input wire logic        resp_valid,
  input wire logic [15:0] resp_wkc,
  input wire logic        done,
  input wire logic        busy,
  input wire logic        error
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  done_err_excl_a: assert property (!(done && error))
    else $error("done with error");
  req_hold_a: assert property (req_valid && !req_ready |=> req_valid && $stable(req_data))
    else $error("request dropped");
  cmd_code_a: assert property (req_valid |-> req_cmd inside {2, 5, 8})
    else $error("bad command");
  len_range_a: assert property (req_valid |-> req_len inside {[1:4]})
    else $error("bad length");
  data_mask_a: assert property (req_valid |-> (req_data >> {req_len, 3'b0}) == 0)
    else $error("data not masked");
  bcast_adp_a: assert property (req_valid && req_cmd == 8 |-> req_adp == 0)
    else $error("broadcast address used");
  done_cause_a: assert property ($rose(done) |-> $past(resp_valid) && $past(resp_wkc) != 0)
    else $error("done without write");
  busy_end_a: assert property (busy && resp_valid |=> !busy && done != error)
    else $error("busy not ended");
  cover property (resp_valid && resp_wkc > 1);
  cover property ((req_valid && !req_ready) [*4]);
  cover property ($rose(error));
endmodule
bind slave_register_write_block slave_register_write_block_chk i_chk (
  .sys_clk, .rst_n, .req_valid, .req_ready, .req_cmd, .req_adp, .req_len, .req_data,
  .resp_valid, .resp_wkc, .done, .busy, .error
);
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "esc_write_defines.vh"
`define CK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb;
  logic        sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, req_data, rd;
  logic [15:0] req_cmd, req_adp, req_ado, resp_wkc, cc, ao, pp;
  logic [2:0]  req_len, nn;
  logic        pready, pslverr, req_valid, req_ready, resp_valid, irq, se;
  logic        done, busy, error;
  int          err_count = 0, comparisons = 0, n_req, nq0;
  slave_register_write_block i_dut (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .req_valid, .req_ready, .req_cmd, .req_adp, .req_ado, .req_len,
    .req_data, .resp_valid, .resp_wkc, .done, .busy, .error, .irq
  );
  esc_net_model i_net (
    .sys_clk, .rst_n, .slow, .req_valid, .req_cmd, .req_adp, .req_ready,
    .resp_valid, .resp_wkc, .n_req
  );
  // Clock
  initial forever #10 sys_clk = ~sys_clk;
  task automatic end_sim;
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One APB transfer, read data kept in rd
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    for (i = 0; i < 9 && pready !== 1'b1; i++)
      @(posedge sys_clk);
    if (i == 9) begin
      err_count++;
      end_sim;
    end
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task automatic start(input logic [15:0] c, p, input logic [2:0] n);
    cc = c;
    nn = n;
    ao = p ^ 16'h0f0f;
    pp = p;
    nq0 = n_req;
    apb(1'b1, `OFS_ADP, {16'h0, p});
    apb(1'b1, `OFS_ADO, {16'h0, ao});
    apb(1'b1, `OFS_LEN, {29'h0, n});
    apb(1'b1, `OFS_CMD, {16'h0, c});
    apb(1'b1, `OFS_VALUE, 32'hd1c2b3a4);
    apb(1'b1, `OFS_CTRL, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h1);
  endtask
  // Wait for the outcome and judge it
  task automatic fin(input logic [15:0] k, f);
    int   i;
    logic sent;
    sent = f == 0 || f == `FAULT_NO_WKC;
    for (i = 0; i < 40 && !(rd[0] || rd[2]); i++)
      apb(1'b0, `OFS_STATUS, 32'h0);
    if (i == 40) begin
      err_count++;
      end_sim;
    end
    `CK(rd[2:0], f ? 3'b100 : 3'b001)
    `CK({error, busy, done}, f ? 3'b100 : 3'b001)
    apb(1'b0, `OFS_FAULT, 32'h0);
    `CK(rd[15:0], f)
    `CK(n_req, nq0 + int'(sent))
    if (sent) begin
      apb(1'b0, `OFS_WKC, 32'h0);
      `CK(rd[15:0], k)
      `CK(req_ado, ao)
      `CK(req_data, 32'hd1c2b3a4 & (32'hffffffff >> (32 - 8 * nn)))
      `CK(req_cmd, cc)
      `CK(req_len, nn)
      `CK(req_adp, cc == `CMD_BWR ? 16'h0 : pp)
    end
  endtask
  task automatic run(input logic [15:0] c, p, input logic [2:0] n, input logic [15:0] k, f);
    rd = 0;
    start(c, p, n);
    fin(k, f);
  endtask
  // Slow network: busy shows, count cleared, retrigger ignored
  task automatic t_busy;
    slow <= 1;
    start(`CMD_BWR, 16'h0, 3'd4);
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CK(rd[2:0], 3'b010)
    `CK({error, busy, done}, 3'b010)
    apb(1'b0, `OFS_WKC, 32'h0);
    `CK(rd[15:0], 16'h0)
    apb(1'b1, `OFS_CTRL, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h1);
    rd = 0;
    fin(16'h3, 16'h0);
    slow <= 0;
  endtask
  // Trigger left high starts nothing more
  task automatic t_hold;
    nq0 = n_req;
    apb(1'b1, `OFS_CTRL, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CK(n_req, nq0)
    `CK(rd[2:0], 3'b001)
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    apb(1'b1, `OFS_INT_MASK, 32'h1);
    run(`CMD_APWR, 16'h0000, 3'd1, 16'h1, 16'h0);
    `CK(irq, 1'b1)
    apb(1'b1, `OFS_INT_STAT, 32'h3);
    `CK(irq, 1'b0)
    t_hold;
    run(`CMD_APWR, 16'hfffe, 3'd2, 16'h1, 16'h0);
    run(`CMD_APWR, 16'hffc1, 3'd3, 16'h0, `FAULT_NO_WKC);
    run(`CMD_APWR, 16'hffc0, 3'd4, 16'h0, `FAULT_ADP);
    run(`CMD_FPWR, 16'd64, 3'd4, 16'h0, `FAULT_NO_WKC);
    run(`CMD_FPWR, 16'd65, 3'd4, 16'h0, `FAULT_ADP);
    run(`CMD_FPWR, 16'd0, 3'd1, 16'h0, `FAULT_ADP);
    run(`CMD_FPWR, 16'd2, 3'd2, 16'h1, 16'h0);
    run(`CMD_BWR, 16'h5555, 3'd3, 16'h3, 16'h0);
    t_busy;
    apb(1'b1, `OFS_INT_STAT, 32'h3);
    run(`CMD_APWR, 16'h0, 3'd0, 16'h0, `FAULT_LEN);
    run(`CMD_FPWR, 16'd99, 3'd5, 16'h0, `FAULT_LEN);
    run(16'h0003, 16'h0, 3'd2, 16'h0, `FAULT_CMD);
    apb(1'b0, `OFS_INT_STAT, 32'h0);
    `CK({rd[1:0], irq}, 3'b100)
    apb(1'b1, `OFS_INT_MASK, 32'h2);
    @(posedge sys_clk);
    `CK(irq, 1'b1)
    apb(1'b0, 8'h40, 32'h0);
    `CK({se, rd}, 33'h100000000)
    end_sim;
  end
endmodule
`default_nettype wire
